//--- hw/cmd_timing_pkg.sv
// constants and carrier types for the command-path mode timing controller
package cmd_timing_pkg;
    localparam int CLK_PERIOD_NS = 10;

    // speed grade select
    localparam logic [1:0] GRADE_2666 = 2'h0;
    localparam logic [1:0] GRADE_2933 = 2'h1;
    localparam logic [1:0] GRADE_3200 = 2'h2;

    // figures in device clocks
    localparam int ALERT_RSP_2666 = 71;
    localparam int ALERT_RSP_2933 = 78;
    localparam int ALERT_RSP_3200 = 85;
    localparam int ALERT_PW_MAX_2666 = 160;
    localparam int ALERT_PW_MAX_2933 = 176;
    localparam int ALERT_PW_MAX_3200 = 192;
    localparam int CAL_2666 = 5;
    localparam int CAL_2933 = 6;
    localparam int CALG_2666 = 6;
    localparam int CALG_2933 = 8;
    localparam int PL_2666 = 5;
    localparam int PL_2933 = 6;

    // figures in ns
    localparam int MPX_LH_MIN_NS = 12;
    localparam int MPX_LH_MARGIN_NS = 10;
    localparam int CTCKE_VALID_NS = 10;
    localparam int CT_VALID_NS = 200;

    // least times round up, longest times round down
    localparam int MPX_LH_CYC = (MPX_LH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CTCKE_CYC = (CTCKE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CT_VALID_CYC = (CT_VALID_NS / CLK_PERIOD_NS < 1) ? 1 : CT_VALID_NS / CLK_PERIOD_NS;

    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // command/address word toward the memory
    typedef struct packed {
        logic [5:0] cmd;
        logic [17:0] addr;
        logic par;
    } ca_word_s;

    typedef struct packed {
        logic cs_n;
        logic cke;
        logic clock_true;
        logic clock_complement;
    } ctl_pins_s;

    // per-mode timing set by the user, in controller clocks
    typedef struct packed {
        logic [CNT_W-1:0] mode_update_delay;
        logic [CNT_W-1:0] cmd_path_disable_delay;
        logic [CNT_W-1:0] clk_after_entry;
        logic [CNT_W-1:0] clk_before_exit;
        logic [CNT_W-1:0] self_refresh_exit_time;
        logic [CNT_W-1:0] dll_lock_exit_time;
        logic [CNT_W-1:0] power_down_exit_time;
    } max_power_saving_mode_timing_s;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_CMD,
        OP_MAX_POWER_SAVING_MODE_ENTER,
        OP_MAX_POWER_SAVING_MODE_EXIT_HIGH,
        OP_MAX_POWER_SAVING_MODE_EXIT_LOW,
        OP_CT_ENTER,
        OP_CT_EXIT
    } op_e;
endpackage

//--- hw/cycle_timer.sv
// down-counting delay timer with load and done flag
`timescale 1ns/10ps
module cycle_timer
    import cmd_timing_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_value,
    output logic done
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        count_nxt = count_r;
        done_nxt = done_r;
        if (load) begin
            count_nxt = load_value;
            done_nxt = (load_value == CNT_ZERO);
        end else if (count_r > CNT_ONE) begin
            count_nxt = count_r - CNT_ONE;
        end else begin
            count_nxt = CNT_ZERO;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_r <= CNT_ZERO;
            done_r <= 1'b1;
        end else begin
            count_r <= count_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule

//--- hw/cmd_path_ctrl.sv
// host-side controller for parity alert, select latency, power saving and connectivity test
`timescale 1ns/10ps
module cmd_path_ctrl
    import cmd_timing_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [1:0] speed_grade,
    input wire logic cal_enable,
    input wire logic gear_down,
    input wire logic persistent_parity,
    input wire max_power_saving_mode_timing_s max_power_saving_mode_timing,
    input wire op_e op,
    input wire logic op_valid,
    input wire ca_word_s op_word,
    input wire logic needs_dll,
    input wire logic alert_n,
    input wire logic [17:0] ct_inputs,
    output logic op_ready,
    output ctl_pins_s pins,
    output ca_word_s ca_out,
    output logic test_enable_pin,
    output logic max_power_saving_mode,
    output logic connectivity_test_mode,
    output logic parity_error,
    output logic ct_sample
);
    typedef enum {
        ST_IDLE, ST_CS_WAIT, ST_ALERT, ST_ENTER_WAIT, ST_MAX_POWER_SAVING_MODE, ST_EXIT_CLK,
        ST_EXIT_HOLD, ST_EXIT_WAIT, ST_CT_CKE, ST_CT, ST_CT_VALID
    } state_e;

    state_e state_r, state_nxt;
    ctl_pins_s pins_r, pins_nxt;
    ca_word_s ca_r, ca_nxt, pend_r, pend_nxt;
    logic ready_r, ready_nxt;
    logic ten_r, ten_nxt;
    logic max_power_saving_mode_r, max_power_saving_mode_nxt;
    logic ct_r, ct_nxt;
    logic perr_r, perr_nxt;
    logic samp_r, samp_nxt;
    logic alert_seen_r, alert_seen_nxt;
    logic exit_low_r, exit_low_nxt;
    logic dll_wait_r, dll_wait_nxt;
    logic tload;
    logic [CNT_W-1:0] tval;
    logic tdone;
    logic [7:0] alert_cnt_r, alert_cnt_nxt;

    function automatic logic [CNT_W-1:0] by_grade(input logic [1:0] g, input int a, input int b, input int c);
        case (g)
            GRADE_2666: by_grade = CNT_W'(a);
            GRADE_2933: by_grade = CNT_W'(b);
            default: by_grade = CNT_W'(c);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] cal_cycles(input logic [1:0] g, input logic gd);
        if (gd)
            cal_cycles = by_grade(g, CALG_2666, CALG_2933, CALG_2933);
        else
            cal_cycles = by_grade(g, CAL_2666, CAL_2933, CAL_2933);
    endfunction

    cycle_timer u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .load(tload),
        .load_value(tval),
        .done(tdone)
    );

    always_comb begin
        state_nxt = state_r;
        pins_nxt = pins_r;
        ca_nxt = ca_r;
        pend_nxt = pend_r;
        ready_nxt = 1'b0;
        ten_nxt = ten_r;
        max_power_saving_mode_nxt = max_power_saving_mode_r;
        ct_nxt = ct_r;
        perr_nxt = 1'b0;
        samp_nxt = 1'b0;
        alert_seen_nxt = alert_seen_r;
        exit_low_nxt = exit_low_r;
        dll_wait_nxt = dll_wait_r;
        alert_cnt_nxt = alert_cnt_r;
        tload = 1'b0;
        tval = CNT_ZERO;
        // free-running differential clock, stopped only inside power saving
        if (!(state_r == ST_MAX_POWER_SAVING_MODE)) begin
            pins_nxt.clock_true = ~pins_r.clock_true;
            pins_nxt.clock_complement = pins_r.clock_true;
        end
        // alert is low-active; count its width for the host's bookkeeping
        if (!alert_n) begin
            alert_seen_nxt = 1'b1;
            if (alert_cnt_r != 8'hff)
                alert_cnt_nxt = alert_cnt_r + 8'h01;
        end else begin
            // re-arm so a later error outside persistent mode is flagged again
            alert_seen_nxt = 1'b0;
            alert_cnt_nxt = 8'h00;
        end
        if (!alert_n && !alert_seen_r)
            perr_nxt = 1'b1;
        case (state_r)
            ST_IDLE: begin
                pins_nxt.cs_n = 1'b1;
                ca_nxt = '0;
                if (!alert_n && !alert_seen_r && persistent_parity) begin
                    // deselect at once, well inside the response window
                    state_nxt = ST_ALERT;
                end else if (op_valid && op_ready) begin
                    case (op)
                        OP_CMD: begin
                            pins_nxt.cs_n = 1'b0;
                            if (cal_enable || gear_down) begin
                                pend_nxt = op_word;
                                tload = 1'b1;
                                tval = cal_cycles(speed_grade, gear_down) - CNT_ONE;
                                state_nxt = ST_CS_WAIT;
                            end else begin
                                ca_nxt = op_word;
                                state_nxt = ST_CS_WAIT;
                                tload = 1'b1;
                                tval = CNT_ZERO;
                            end
                        end
                        OP_MAX_POWER_SAVING_MODE_ENTER: begin
                            max_power_saving_mode_nxt = 1'b1;
                            tload = 1'b1;
                            // clock held valid over the whole entry and disable time
                            tval = max_power_saving_mode_timing.clk_after_entry + max_power_saving_mode_timing.mode_update_delay
                                + max_power_saving_mode_timing.cmd_path_disable_delay;
                            state_nxt = ST_ENTER_WAIT;
                        end
                        OP_CT_ENTER: begin
                            ten_nxt = 1'b1;
                            pins_nxt.cke = 1'b1;
                            tload = 1'b1;
                            tval = CNT_W'(CTCKE_CYC);
                            state_nxt = ST_CT_CKE;
                        end
                        default: ;
                    endcase
                end else begin
                    ready_nxt = 1'b1;
                end
            end
            ST_CS_WAIT: begin
                pins_nxt.cs_n = 1'b1;
                if (tdone) begin
                    if (cal_enable || gear_down)
                        ca_nxt = pend_r;
                    state_nxt = ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            ST_ALERT: begin
                pins_nxt.cs_n = 1'b1;
                ca_nxt = '0;
                // hold deselect until alert releases; parity latency window commands are void
                if (alert_n) begin
                    alert_seen_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            ST_ENTER_WAIT: begin
                pins_nxt.cs_n = 1'b1;
                if (tdone) begin
                    state_nxt = ST_MAX_POWER_SAVING_MODE;
                    ready_nxt = 1'b1;
                end
            end
            ST_MAX_POWER_SAVING_MODE: begin
                ready_nxt = 1'b1;
                if (op_valid && op_ready && (op == OP_MAX_POWER_SAVING_MODE_EXIT_HIGH || op == OP_MAX_POWER_SAVING_MODE_EXIT_LOW)) begin
                    ready_nxt = 1'b0;
                    exit_low_nxt = (op == OP_MAX_POWER_SAVING_MODE_EXIT_LOW);
                    dll_wait_nxt = needs_dll;
                    pins_nxt.cke = 1'b0;
                    tload = 1'b1;
                    tval = max_power_saving_mode_timing.clk_before_exit;
                    state_nxt = ST_EXIT_CLK;
                end
            end
            ST_EXIT_CLK: begin
                if (tdone) begin
                    pins_nxt.cke = 1'b1;
                    pins_nxt.cs_n = !exit_low_r;
                    tload = 1'b1;
                    // timer adds one state step, so the low hold is loaded one short
                    tval = exit_low_r ? CNT_W'(MPX_LH_CYC) - CNT_ONE
                        : max_power_saving_mode_timing.power_down_exit_time;
                    state_nxt = ST_EXIT_HOLD;
                end
            end
            ST_EXIT_HOLD: begin
                if (tdone) begin
                    // low hold released at the earliest legal point, under exit delay minus 10 ns
                    pins_nxt.cs_n = 1'b1;
                    max_power_saving_mode_nxt = 1'b0;
                    tload = 1'b1;
                    tval = dll_wait_r ? max_power_saving_mode_timing.self_refresh_exit_time + max_power_saving_mode_timing.dll_lock_exit_time
                        : max_power_saving_mode_timing.self_refresh_exit_time;
                    state_nxt = ST_EXIT_WAIT;
                end
            end
            ST_EXIT_WAIT: begin
                if (tdone) begin
                    state_nxt = ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            ST_CT_CKE: begin
                if (tdone) begin
                    ct_nxt = 1'b1;
                    pins_nxt.cs_n = 1'b0;
                    ca_nxt.addr = ct_inputs;
                    tload = 1'b1;
                    tval = CNT_W'(CT_VALID_CYC);
                    state_nxt = ST_CT_VALID;
                end
            end
            ST_CT_VALID: begin
                ca_nxt.addr = ct_inputs;
                if (tdone) begin
                    samp_nxt = 1'b1;
                    state_nxt = ST_CT;
                    ready_nxt = 1'b1;
                end
            end
            ST_CT: begin
                ready_nxt = 1'b1;
                if (op_valid && op_ready && op == OP_CT_EXIT) begin
                    ready_nxt = 1'b0;
                    ten_nxt = 1'b0;
                    ct_nxt = 1'b0;
                    pins_nxt.cs_n = 1'b1;
                    state_nxt = ST_IDLE;
                end else if (op_valid && op_ready && op == OP_CMD) begin
                    ready_nxt = 1'b0;
                    ca_nxt.addr = ct_inputs;
                    tload = 1'b1;
                    tval = CNT_W'(CT_VALID_CYC);
                    state_nxt = ST_CT_VALID;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            pins_r <= '{cs_n: 1'b1, cke: 1'b1, clock_true: 1'b0, clock_complement: 1'b1};
            ca_r <= '0;
            pend_r <= '0;
            ready_r <= 1'b0;
            ten_r <= 1'b0;
            max_power_saving_mode_r <= 1'b0;
            ct_r <= 1'b0;
            perr_r <= 1'b0;
            samp_r <= 1'b0;
            alert_seen_r <= 1'b0;
            exit_low_r <= 1'b0;
            dll_wait_r <= 1'b0;
            alert_cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            ca_r <= ca_nxt;
            pend_r <= pend_nxt;
            ready_r <= ready_nxt;
            ten_r <= ten_nxt;
            max_power_saving_mode_r <= max_power_saving_mode_nxt;
            ct_r <= ct_nxt;
            perr_r <= perr_nxt;
            samp_r <= samp_nxt;
            alert_seen_r <= alert_seen_nxt;
            exit_low_r <= exit_low_nxt;
            dll_wait_r <= dll_wait_nxt;
            alert_cnt_r <= alert_cnt_nxt;
        end
    end

    assign op_ready = ready_r;
    assign pins = pins_r;
    assign ca_out = ca_r;
    assign test_enable_pin = ten_r;
    assign max_power_saving_mode = max_power_saving_mode_r;
    assign connectivity_test_mode = ct_r;
    assign parity_error = perr_r;
    assign ct_sample = samp_r;
endmodule

//--- verif/cmd_path_ctrl_asserts.sv
// concurrent checks on the command-path controller ports
`timescale 1ns/10ps
module cmd_path_ctrl_asserts
    import cmd_timing_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [1:0] speed_grade,
    input wire logic cal_enable,
    input wire logic gear_down,
    input wire logic persistent_parity,
    input wire max_power_saving_mode_timing_s max_power_saving_mode_timing,
    input wire logic needs_dll,
    input wire logic alert_n,
    input wire logic op_ready,
    input wire ctl_pins_s pins,
    input wire ca_word_s ca_out,
    input wire logic test_enable_pin,
    input wire logic max_power_saving_mode,
    input wire logic parity_error,
    input wire logic ct_sample
);
    logic [CNT_W-1:0] up_r, up_nxt, tog_r, tog_nxt;
    logic cke_r, cke_nxt, ck_r, ck_nxt;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // cycles since clock enable rose, saturating so old exits never look recent
    always_comb begin
        up_nxt = (up_r == 12'hfff) ? up_r : up_r + CNT_ONE;
        if (pins.cke && !cke_r) begin
            up_nxt = CNT_ZERO;
        end
        tog_nxt = (pins.clock_true != ck_r) ? tog_r + CNT_ONE : CNT_ZERO;
        cke_nxt = pins.cke;
        ck_nxt = pins.clock_true;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            up_r <= 12'hfff;
            tog_r <= CNT_ZERO;
            cke_r <= 1'b1;
            ck_r <= 1'b0;
        end else begin
            up_r <= up_nxt;
            tog_r <= tog_nxt;
            cke_r <= cke_nxt;
            ck_r <= ck_nxt;
        end
    end

    a_alert_deselect: assert property ($fell(alert_n) && persistent_parity |-> ##71 (alert_n || pins.cs_n))
        else $error("command sent during persistent alert");
    a_alert_flag: assert property ($fell(alert_n) |-> ##1 parity_error ##1 !parity_error)
        else $error("parity flag not a single pulse");
    a_cal_offset: assert property ($fell(pins.cs_n) && pins.cke && !test_enable_pin && cal_enable
        && !gear_down && speed_grade == GRADE_2666 |-> $stable(ca_out)[*4])
        else $error("command bits ahead of select offset");
    a_geardown_offset: assert property ($fell(pins.cs_n) && pins.cke && !test_enable_pin && gear_down
        && speed_grade != GRADE_2666 |-> $stable(ca_out)[*7])
        else $error("command bits ahead of gear-down offset");
    a_entry_clock: assert property ($rose(max_power_saving_mode) |-> $changed(pins.clock_true)[*4])
        else $error("clock stopped too soon after entry");
    a_exit_clock: assert property ($rose(pins.cke) |-> tog_nxt >= max_power_saving_mode_timing.clk_before_exit)
        else $error("clock not running before exit");
    a_high_hold: assert property ($fell(pins.cs_n) && pins.cke && !$rose(pins.cke)
        |-> {1'b0, up_r} + 13'h0001 >= {1'b0, max_power_saving_mode_timing.power_down_exit_time})
        else $error("select high hold too short");
    a_low_hold: assert property ($rose(pins.cke) && !pins.cs_n |-> !pins.cs_n[*2] ##1 pins.cs_n)
        else $error("select low hold wrong");
    a_exit_plain: assert property ($rose(op_ready) && !needs_dll |-> up_r >= max_power_saving_mode_timing.self_refresh_exit_time)
        else $error("ready too soon after exit");
    a_exit_dll: assert property ($rose(op_ready) && needs_dll
        |-> {1'b0, up_r} >= {1'b0, max_power_saving_mode_timing.self_refresh_exit_time} + {1'b0, max_power_saving_mode_timing.dll_lock_exit_time})
        else $error("ready too soon after exit with lock");
    a_test_entry: assert property ($rose(test_enable_pin) |-> ##1 (pins.cke && $changed(pins.clock_true)))
        else $error("clock or enable missing in test entry");

    c_alert: cover property ($fell(alert_n) && persistent_parity);
    c_low_exit: cover property ($rose(pins.cke) && !pins.cs_n);
    c_high_exit: cover property ($rose(pins.cke) && pins.cs_n);
    c_test: cover property (ct_sample);
endmodule

bind cmd_path_ctrl cmd_path_ctrl_asserts chk (
    .sys_clk(sys_clk), .reset(reset), .speed_grade(speed_grade), .cal_enable(cal_enable),
    .gear_down(gear_down), .persistent_parity(persistent_parity), .max_power_saving_mode_timing(max_power_saving_mode_timing),
    .needs_dll(needs_dll), .alert_n(alert_n), .op_ready(op_ready), .pins(pins), .ca_out(ca_out),
    .test_enable_pin(test_enable_pin), .parity_error(parity_error), .ct_sample(ct_sample),
    .max_power_saving_mode(max_power_saving_mode)
);

//--- verif/ddr_dev_model.sv
// device stand-in: command parity check and alert pulse
`timescale 1ns/10ps
module ddr_dev_model
    import cmd_timing_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [1:0] speed_grade,
    input wire ctl_pins_s pins,
    input wire ca_word_s ca_out,
    input wire logic test_enable_pin,
    input wire logic max_power_saving_mode,
    output logic alert_n
);
    int lat_r;
    int wid_r;
    // pulled up, so a released alert reads high
    assign alert_n = (wid_r == 0);
    always @(posedge sys_clk) begin
        if (reset) begin
            lat_r <= 0;
            wid_r <= 0;
        end else if (lat_r > 1) begin
            lat_r <= lat_r - 1;
        end else if (lat_r == 1) begin
            lat_r <= 0;
            // shortest legal pulse is the harshest case for the host
            wid_r <= (speed_grade == GRADE_2666) ? 80 : ((speed_grade == GRADE_2933) ? 88 : 96);
        end else if (wid_r > 0) begin
            wid_r <= wid_r - 1;
        end else if (!pins.cs_n && pins.cke && !test_enable_pin && !max_power_saving_mode && ^ca_out) begin
            // parity checked at select only; latency modes are not modelled
            lat_r <= (speed_grade == GRADE_2666) ? PL_2666 : PL_2933;
        end
    end
endmodule

//--- verif/ddr4_cmd_path_mode_timing_bench.sv
// self-checking bench for the command-path controller
`timescale 1ns/10ps
module ddr4_cmd_path_mode_timing_bench;
    import cmd_timing_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] speed_grade = GRADE_2666;
    logic cal_enable = 1'b0;
    logic gear_down = 1'b0;
    logic persistent_parity = 1'b0;
    max_power_saving_mode_timing_s max_power_saving_mode_timing = {12'h004, 12'h004, 12'h004, 12'h004, 12'h004, 12'h006, 12'h004};
    op_e op = OP_NONE;
    logic op_valid = 1'b0;
    ca_word_s op_word = '0;
    logic needs_dll = 1'b0;
    logic [17:0] ct_inputs = 18'h00000;
    logic alert_n, op_ready, test_enable_pin, max_power_saving_mode, connectivity_test_mode, parity_error, ct_sample;
    ctl_pins_s pins;
    ca_word_s ca_out;
    int fails = 0;
    int samples_checked = 0;

    always #5 sys_clk = ~sys_clk;

    cmd_path_ctrl dut (.sys_clk(sys_clk), .reset(reset), .speed_grade(speed_grade), .cal_enable(cal_enable),
        .gear_down(gear_down), .persistent_parity(persistent_parity), .max_power_saving_mode_timing(max_power_saving_mode_timing), .op(op),
        .op_valid(op_valid), .op_word(op_word), .needs_dll(needs_dll), .alert_n(alert_n), .ct_inputs(ct_inputs),
        .op_ready(op_ready), .pins(pins), .ca_out(ca_out), .test_enable_pin(test_enable_pin),
        .max_power_saving_mode(max_power_saving_mode), .connectivity_test_mode(connectivity_test_mode),
        .parity_error(parity_error), .ct_sample(ct_sample));
    ddr_dev_model dev (.sys_clk(sys_clk), .reset(reset), .speed_grade(speed_grade), .pins(pins), .ca_out(ca_out),
        .test_enable_pin(test_enable_pin), .max_power_saving_mode(max_power_saving_mode), .alert_n(alert_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one clock of a bounded wait
    task automatic tick(input int lim, inout int n);
        @(posedge sys_clk);
        n++;
        if (n > lim) begin
            fails++;
            $display("[ERR] %0t wait ran out", $time);
            tally_and_finish();
        end
    endtask

    task automatic issue(input op_e o, input ca_word_s w);
        int n;
        n = 0;
        tick(500, n);
        while (op_ready !== 1'b1) tick(500, n);
        op <= o;
        op_word <= w;
        op_valid <= 1'b1;
        @(posedge sys_clk);
        op_valid <= 1'b0;
    endtask

    function automatic ca_word_s word(input logic [5:0] c, input logic [17:0] a, input logic bad);
        return {c, a, (^{c, a}) ^ bad};
    endfunction

    task automatic t_latency;
        ca_word_s w;
        int n;
        int exp_n [5] = '{0, CAL_2666, CAL_2933, CALG_2666, CALG_2933};
        logic [1:0] gr [5] = '{GRADE_2666, GRADE_2666, GRADE_3200, GRADE_2666, GRADE_2933};
        for (int i = 0; i < 5; i++) begin
            speed_grade <= gr[i];
            cal_enable <= (i > 0);
            gear_down <= (i > 2);
            w = word(6'h05, 18'h1a5c3 + 18'(i), 1'b0);
            issue(OP_CMD, w);
            n = 0;
            while (pins.cs_n !== 1'b0) tick(20, n);
            n = 0;
            while (ca_out !== w) tick(20, n);
            check(n >= exp_n[i], 1'b1);
            check(n <= exp_n[i] + 1, 1'b1);
        end
        speed_grade <= GRADE_2666;
        cal_enable <= 1'b0;
        gear_down <= 1'b0;
        $display("latency test done");
    endtask

    task automatic t_parity;
        int n;
        persistent_parity <= 1'b1;
        issue(OP_CMD, word(6'h11, 18'h00f0f, 1'b1));
        n = 0;
        while (alert_n !== 1'b0) tick(20, n);
        @(posedge sys_clk);
        check(parity_error, 1'b1);
        n = 0;
        while (alert_n === 1'b0) begin
            check(pins.cs_n, 1'b1);
            tick(300, n);
        end
        persistent_parity <= 1'b0;
        $display("parity test done");
    endtask

    task automatic t_max_power_saving_mode(input logic low, input logic dll);
        ca_word_s w;
        int n;
        logic c;
        w = word(6'h22, 18'h3c3c3, 1'b0);
        issue(OP_MAX_POWER_SAVING_MODE_ENTER, w);
        // a command while saving power must be swallowed
        issue(OP_CMD, w);
        check(max_power_saving_mode, 1'b1);
        repeat (4) begin
            c = pins.clock_true;
            @(posedge sys_clk);
            check({pins.clock_true, pins.clock_complement, pins.cs_n}, {c, ~c, 1'b1});
        end
        needs_dll <= dll;
        issue(low ? OP_MAX_POWER_SAVING_MODE_EXIT_LOW : OP_MAX_POWER_SAVING_MODE_EXIT_HIGH, w);
        n = 0;
        while (pins.cke !== 1'b0) tick(20, n);
        while (pins.cke !== 1'b1) tick(60, n);
        check(pins.cs_n, !low);
        n = 0;
        while (op_ready !== 1'b1) tick(60, n);
        check(n >= 4 + (dll ? 6 : 0), 1'b1);
        check(max_power_saving_mode, 1'b0);
        needs_dll <= 1'b0;
        $display("power saving test done");
    endtask

    task automatic t_ct;
        int n;
        ct_inputs <= 18'h2d4b1;
        issue(OP_CT_ENTER, '0);
        n = 0;
        while (ct_sample !== 1'b1) tick(40, n);
        check(n >= CT_VALID_CYC, 1'b1);
        check({test_enable_pin, pins.cke, pins.cs_n}, 3'b110);
        check(ca_out.addr, 18'h2d4b1);
        check(connectivity_test_mode, 1'b1);
        ct_inputs <= 18'h12a4e;
        issue(OP_CMD, '0);
        n = 0;
        // ready still shows the pre-take level in the take edge's time step
        while (op_ready !== 1'b0) tick(40, n);
        while (op_ready !== 1'b1) tick(40, n);
        check(ca_out.addr, 18'h12a4e);
        issue(OP_CT_EXIT, '0);
        repeat (3) @(posedge sys_clk);
        check({test_enable_pin, connectivity_test_mode}, 2'b00);
        $display("test mode done");
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        check({pins.cs_n, pins.cke, op_ready}, 3'b110);
        reset <= 1'b0;
        t_latency();
        t_parity();
        t_max_power_saving_mode(1'b1, 1'b0);
        t_max_power_saving_mode(1'b0, 1'b1);
        t_ct();
        tally_and_finish();
    end
endmodule
